// >>> pkg/rmcc_pkg.sv
// Constants and types shared by the mode command control word block
package rmcc_pkg;

	// ********************************************************
	// Register offsets (byte addresses on APB)
	// ********************************************************
	localparam logic [7:0] OFS_CTRL_WORD  = 8'h00;
	localparam logic [7:0] OFS_CONFIG     = 8'h04;
	localparam logic [7:0] OFS_COMMAND    = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;

	// ********************************************************
	// Control word fields
	// ********************************************************
	localparam int BIT_IRQ_ON_INDEX_ZERO = 15;
	localparam int BIT_IRQ_ON_ACCESS     = 14;
	localparam int BIT_MAKE_BUSY         = 12;
	localparam int BIT_DESC_ACCESSED     = 11;
	localparam int BIT_PTR_SELECT        = 10;
	localparam int BIT_BROADCAST         = 9;
	localparam int BIT_DBUF_ACTIVE       = 8;
	localparam int IDX_MSB               = 7;
	localparam int IDX_LSB               = 4;
	localparam int BIT_STOP_DBUF         = 3;
	localparam int BIT_DBUF_ENABLE       = 2;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;

	// ********************************************************
	// Configuration register fields
	// ********************************************************
	localparam int CFG_SIMPLIFIED = 0;
	localparam int CFG_TERM_EN    = 1;
	localparam int CFG_TERM_EXEC  = 2;
	localparam int CFG_GEN_IDXZ   = 3;
	localparam int CFG_GEN_ACCESS = 4;
	localparam int CFG_WIDTH      = 5;
	localparam logic [4:0] CFG_RESET = 5'h00;
	localparam int CMD_SW_RESET   = 0;

	// ********************************************************
	// Interrupt bits and log codes
	// ********************************************************
	localparam int IRQ_WIDTH      = 2;
	localparam int IRQ_IDX_ZERO   = 0;
	localparam int IRQ_ACCESS     = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// ********************************************************
	// Command decode values
	// ********************************************************
	localparam logic [4:0] SUBADDR_MODE_LOW  = 5'h00;
	localparam logic [4:0] SUBADDR_MODE_HIGH = 5'h1F;
	localparam logic [4:0] MODE_CODE_DATA    = 5'h10;
	localparam logic [3:0] IDX_ONE           = 4'h1;
	localparam logic [3:0] IDX_ZERO          = 4'h0;

	typedef enum logic [1:0] {
		BUF_INDEXED,
		BUF_DOUBLE,
		BUF_SIMPLIFIED
	} rmcc_buf_mode_type;

endpackage

// >>> logic/rmcc_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain
module rmcc_sync
(
	input  wire logic i_sys_clk, // System clock
	input  wire logic i_resetn,  // Asynchronous reset, active low
	input  wire logic i_async,   // Level from a pin
	output logic      o_sync     // Level in the clock domain
);

	logic stage_one;

	// ********************************************************
	// Synchroniser chain
	// ********************************************************
	// First stage feeds only the second one
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			stage_one <= 1'b0;
			o_sync    <= 1'b0;
		end
		else
		begin
			stage_one <= i_async;
			o_sync    <= stage_one;
		end
	end

endmodule

// >>> logic/rmcc_irq_bits.sv
// Sticky interrupt status with write-one-to-clear, mask and level output
module rmcc_irq_bits
#(
	parameter int WIDTH = 2 // Number of event bits
)
(
	input  wire logic             i_sys_clk,  // System clock
	input  wire logic             i_resetn,   // Asynchronous reset, active low
	input  wire logic [WIDTH-1:0] i_set,      // Event pulses
	input  wire logic             i_clr_wr,   // Status write strobe
	input  wire logic [WIDTH-1:0] i_clr_data, // Ones clear status bits
	input  wire logic             i_mask_wr,  // Mask write strobe
	input  wire logic [WIDTH-1:0] i_mask_data,// New mask value
	output logic      [WIDTH-1:0] o_status,   // Sticky status
	output logic      [WIDTH-1:0] o_mask,     // Mask, one enables
	output logic                  o_irq       // Level interrupt
);

	// ********************************************************
	// Status bits
	// ********************************************************
	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_status <= '0;
		else if (i_clr_wr)
			o_status <= (o_status & ~i_clr_data) | i_set;
		else
			o_status <= o_status | i_set;
	end

	// Mask register
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_mask <= '0;
		else if (i_mask_wr)
			o_mask <= i_mask_data;
	end

	// Output stays high while any enabled status bit is set
	assign o_irq = |(o_status & o_mask);

endmodule

// >>> logic/rmcc_top.sv
// Receive mode command control word, buffer mode choice and interrupts
//
// What this block does
// - Mode commands never use circular buffering; only indexed, double or simplified.
// - Simplified bit clear: per-word double buffer enable picks double or indexed.
// - Simplified bit set: per-word double buffer enable is ignored.
// - Simplified mode stores info, time tag, data of codes 16-31 in descriptor.
// - Simplified mode follows no data buffer pointers.
// - Simplified mode freezes index and pointer select and clears bit 8; only the access interrupt can fire.
// - Receive control word serves receive commands with subaddress 0 or 31.
// - Bits 8-11 ignore host writes; device updates them only while executing.
// - Bit 2 host-writable only when not executing; 3 and 12-15 always.
// - Master reset clears the whole control word.
// - Software reset clears only accessed, pointer select and broadcast bits.
// - A read of the control word clears the accessed bit unless a message finishes in the same cycle.
// - Index stepping 1 to 0 with both enables raises, flags and logs.
// - Each valid receive mode command with both access enables raises and logs.
// - Double buffering toggles pointer select after each error-free message not answered with busy.
// - Device sets the accessed bit when it finishes a message.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module rmcc_top
(
	input  wire logic        i_sys_clk,         // System clock, 50 MHz
	input  wire logic        i_resetn,          // Async reset, active low
	input  wire logic        i_master_reset_pin,// Master reset pin, high
	input  wire logic        i_psel,            // APB select
	input  wire logic        i_penable,         // APB enable
	input  wire logic        i_pwrite,          // APB direction
	input  wire logic [7:0]  i_paddr,           // APB byte address
	input  wire logic [31:0] i_pwdata,          // APB write data
	output logic      [31:0] o_prdata,          // APB read data
	output logic             o_pready,          // APB ready
	output logic             o_pslverr,         // APB error
	input  wire logic        i_msg_done,        // Message finished pulse
	input  wire logic        i_msg_valid,       // Valid mode command
	input  wire logic        i_msg_tr,          // Command T/R bit
	input  wire logic [4:0]  i_msg_subaddr,     // Command subaddress
	input  wire logic [4:0]  i_msg_mode_code,   // Mode code field
	input  wire logic        i_msg_error_free,  // No error in message
	input  wire logic        i_msg_broadcast,   // Broadcast command
	output rmcc_pkg::rmcc_buf_mode_type o_buffer_mode, // Active buffering
	output logic             o_rx_word_select,  // Receive word applies
	output logic             o_use_pointer_b,   // Next message uses B
	output logic             o_follow_data_ptr, // Data pointers in use
	output logic             o_store_in_desc,   // Data kept in descriptor
	output logic             o_make_busy,       // Answer with busy
	output logic             o_log_valid,       // Log entry pulse
	output logic [1:0]       o_log_code,        // Log entry cause
	output logic             o_irq              // Interrupt, active high
);

	import rmcc_pkg::*;

	// ********************************************************
	// Declarations
	// ********************************************************
	logic                 mr_sync;
	logic [15:0]          ctrl_word;
	logic [4:0]           host_bits;  // Bits 15-12, then bit 3
	logic                 double_buffer_enable;
	logic                 double_buffer_active;
	logic                 buffer_pointer_select;
	logic                 broadcast_flag;
	logic                 descriptor_accessed;
	logic [CFG_WIDTH-1:0] config_reg;
	logic                 simplified;
	logic                 term_enable;
	logic                 term_execute;
	logic                 apb_wr;
	logic                 apb_rd;
	logic                 addr_ok;
	logic                 sw_reset;
	logic                 ctrl_wr;
	logic                 ctrl_rd;
	logic                 msg_done;
	logic [3:0]           index_count;
	logic                 idx_zero_evt;
	logic                 access_evt;
	logic [IRQ_WIDTH-1:0] irq_set;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [31:0]          next_prdata;

	// ********************************************************
	// Master reset pin
	// ********************************************************
	// Pin is asynchronous, so it is synchronised before use
	rmcc_sync u_mr_sync
	(
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_async   (i_master_reset_pin),
		.o_sync    (mr_sync)
	);

	// ********************************************************
	// APB decode
	// ********************************************************
	// Zero wait states: every access ends in its first access cycle
	assign o_pready = 1'b1;
	assign apb_wr   = i_psel & i_penable & i_pwrite;
	assign apb_rd   = i_psel & i_penable & ~i_pwrite;

	// Address check for the error answer
	always_comb
	begin
		unique case (i_paddr)
			OFS_CTRL_WORD, OFS_CONFIG, OFS_COMMAND,
			OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_STATUS: addr_ok = 1'b1;
			default:                                  addr_ok = 1'b0;
		endcase
	end

	assign o_pslverr = i_psel & i_penable & ~addr_ok;
	assign ctrl_wr   = apb_wr & (i_paddr == OFS_CTRL_WORD);
	assign ctrl_rd   = apb_rd & (i_paddr == OFS_CTRL_WORD);
	assign sw_reset  = apb_wr & (i_paddr == OFS_COMMAND)
		& i_pwdata[CMD_SW_RESET];

	// ********************************************************
	// Configuration register
	// ********************************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			config_reg <= CFG_RESET;
		else if (mr_sync)
			config_reg <= CFG_RESET;
		else if (apb_wr && i_paddr == OFS_CONFIG)
			config_reg <= i_pwdata[CFG_WIDTH-1:0];
	end

	assign simplified   = config_reg[CFG_SIMPLIFIED];
	assign term_enable  = config_reg[CFG_TERM_EN];
	assign term_execute = config_reg[CFG_TERM_EXEC];

	// ********************************************************
	// Command decode and buffer mode
	// ********************************************************
	// Receive word serves receive mode commands only
	assign o_rx_word_select = ~i_msg_tr
		& (i_msg_subaddr == SUBADDR_MODE_LOW
		| i_msg_subaddr == SUBADDR_MODE_HIGH);
	assign msg_done = term_execute & i_msg_done & i_msg_valid
		& o_rx_word_select;

	// No circular choice exists for mode commands
	always_comb
	begin
		if (simplified)
			o_buffer_mode = BUF_SIMPLIFIED;
		else if (ctrl_word[BIT_DBUF_ENABLE])
			o_buffer_mode = BUF_DOUBLE;
		else
			o_buffer_mode = BUF_INDEXED;
	end

	// Simplified mode keeps data inside the descriptor block
	assign o_follow_data_ptr = ~simplified;
	assign o_store_in_desc   = simplified
		& (i_msg_mode_code >= MODE_CODE_DATA);
	assign o_use_pointer_b   = ctrl_word[BIT_PTR_SELECT];
	assign o_make_busy       = ctrl_word[BIT_MAKE_BUSY];

	// ********************************************************
	// Host-owned control word bits
	// ********************************************************
	// Bits 3 and 12-15 take writes at any time
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			host_bits <= {CTRL_RESET[15:12], CTRL_RESET[BIT_STOP_DBUF]};
		else if (mr_sync)
			host_bits <= {CTRL_RESET[15:12], CTRL_RESET[BIT_STOP_DBUF]};
		else if (ctrl_wr)
			host_bits <= {i_pwdata[15:12], i_pwdata[BIT_STOP_DBUF]};
	end

	// Enable bit is frozen while the terminal executes
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			double_buffer_enable <= 1'b0;
		else if (mr_sync)
			double_buffer_enable <= 1'b0;
		else if (ctrl_wr && !term_execute)
			double_buffer_enable <= i_pwdata[BIT_DBUF_ENABLE];
	end

	// One driver per bit; circular enables read as zero
	assign ctrl_word = {host_bits[4:1], descriptor_accessed,
		buffer_pointer_select, broadcast_flag, double_buffer_active,
		index_count, host_bits[0], double_buffer_enable, 2'b00};

	// ********************************************************
	// Message index count
	// ********************************************************
	// Host loads it while stopped, device steps it while running
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			index_count <= IDX_ZERO;
		else if (mr_sync)
			index_count <= IDX_ZERO;
		else if (ctrl_wr && !term_execute)
			index_count <= i_pwdata[IDX_MSB:IDX_LSB];
		else if (msg_done && o_buffer_mode == BUF_INDEXED
			&& index_count != IDX_ZERO)
			index_count <= index_count - IDX_ONE;
	end

	// ********************************************************
	// Device-owned status bits 8 to 11
	// ********************************************************
	// Double buffering is confirmed only while enabled and running;
	// an enable bit written before enable still counts, as it is recomputed every running cycle
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			double_buffer_active <= 1'b0;
		else if (mr_sync)
			double_buffer_active <= 1'b0;
		else if (term_execute)
			double_buffer_active <= term_enable & ~simplified
				& double_buffer_enable & ~host_bits[0];
	end

	// Pointer flips only on good, non-busy double buffer messages
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			buffer_pointer_select <= 1'b0;
		else if (mr_sync || sw_reset)
			buffer_pointer_select <= 1'b0;
		else if (msg_done && o_buffer_mode == BUF_DOUBLE
			&& double_buffer_active && i_msg_error_free
			&& !o_make_busy)
			buffer_pointer_select <= ~buffer_pointer_select;
	end

	// Broadcast flag follows the last finished message
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			broadcast_flag <= 1'b0;
		else if (mr_sync || sw_reset)
			broadcast_flag <= 1'b0;
		else if (msg_done)
			broadcast_flag <= i_msg_broadcast;
	end

	// Completion set is checked first so a read cannot swallow it
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			descriptor_accessed <= 1'b0;
		else if (mr_sync)
			descriptor_accessed <= 1'b0;
		else if (msg_done)
			descriptor_accessed <= 1'b1;
		else if (sw_reset || ctrl_rd)
			descriptor_accessed <= 1'b0;
	end

	// ********************************************************
	// Interrupt events
	// ********************************************************
	// Index-zero event in indexed mode only; access event in every mode, simplified included
	assign idx_zero_evt = msg_done && o_buffer_mode == BUF_INDEXED
		&& index_count == IDX_ONE
		&& ctrl_word[BIT_IRQ_ON_INDEX_ZERO]
		&& config_reg[CFG_GEN_IDXZ];
	assign access_evt   = msg_done && ctrl_word[BIT_IRQ_ON_ACCESS]
		&& config_reg[CFG_GEN_ACCESS];

	always_comb
	begin
		irq_set               = '0;
		irq_set[IRQ_IDX_ZERO] = idx_zero_evt;
		irq_set[IRQ_ACCESS]   = access_evt;
	end

	rmcc_irq_bits #(.WIDTH(IRQ_WIDTH)) u_irq
	(
		.i_sys_clk   (i_sys_clk),
		.i_resetn    (i_resetn),
		.i_set       (irq_set),
		.i_clr_wr    (apb_wr && i_paddr == OFS_IRQ_STATUS),
		.i_clr_data  (i_pwdata[IRQ_WIDTH-1:0]),
		.i_mask_wr   (apb_wr && i_paddr == OFS_IRQ_MASK),
		.i_mask_data (i_pwdata[IRQ_WIDTH-1:0]),
		.o_status    (irq_status),
		.o_mask      (irq_mask),
		.o_irq       (o_irq)
	);

	// ********************************************************
	// Interrupt log strobe
	// ********************************************************
	// Cause bits share the status layout, so both can log at once
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			{o_log_valid, o_log_code} <= 3'h0;
		else
			{o_log_valid, o_log_code} <= {|irq_set, irq_set};
	end

	// ********************************************************
	// Read data
	// ********************************************************
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		unique case (i_paddr)
			OFS_CTRL_WORD:  next_prdata[15:0] = ctrl_word;
			OFS_CONFIG:     next_prdata[CFG_WIDTH-1:0] = config_reg;
			OFS_IRQ_STATUS: next_prdata[IRQ_WIDTH-1:0] = irq_status;
			OFS_IRQ_MASK:   next_prdata[IRQ_WIDTH-1:0] = irq_mask;
			OFS_STATUS:     next_prdata[1:0] = o_buffer_mode;
			default:        next_prdata = 32'h0000_0000;
		endcase
	end

	// Combinational read keeps the slave at zero wait states
	assign o_prdata = apb_rd ? next_prdata : 32'h0000_0000;

endmodule

// >>> tb/rmcc_props.sv
// Concurrent checks on the control word block ports
module rmcc_props
(
	input logic                        i_sys_clk,         // Clock
	input logic                        i_resetn,          // Reset, low
	input logic                        i_psel,            // APB select
	input logic                        i_penable,         // APB enable
	input logic                        i_pwrite,          // APB direction
	input logic                        i_msg_done,        // Message end
	input logic                        i_msg_valid,       // Valid command
	input logic                        i_msg_tr,          // T/R bit
	input logic [4:0]                  i_msg_subaddr,     // Subaddress
	input logic [4:0]                  i_msg_mode_code,   // Mode code
	input logic                        i_msg_error_free,  // Error free
	input rmcc_pkg::rmcc_buf_mode_type o_buffer_mode,     // Buffering
	input logic                        o_rx_word_select,  // Word applies
	input logic                        o_use_pointer_b,   // Pointer B
	input logic                        o_follow_data_ptr, // Pointers used
	input logic                        o_store_in_desc,   // In descriptor
	input logic                        o_make_busy,       // Busy answer
	input logic                        o_log_valid,       // Log pulse
	input logic [1:0]                  o_log_code,        // Log cause
	input logic                        o_irq              // Interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	import rmcc_pkg::*;

	// ************************************************
	// Properties
	// ************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	property p_no_circ;
		o_buffer_mode inside {BUF_INDEXED, BUF_DOUBLE, BUF_SIMPLIFIED};
	endproperty
	a_no_circ: assert property (p_no_circ)
		else $error("buffer mode outside the three kinds");
	property p_rx_sel;
		o_rx_word_select == (!i_msg_tr && (i_msg_subaddr == 5'h00
			|| i_msg_subaddr == 5'h1F));
	endproperty
	a_rx_sel: assert property (p_rx_sel)
		else $error("receive word select wrong");
	property p_store;
		o_store_in_desc == (o_buffer_mode == BUF_SIMPLIFIED
			&& i_msg_mode_code >= 5'h10);
	endproperty
	a_store: assert property (p_store)
		else $error("descriptor storage wrong");
	property p_follow;
		o_follow_data_ptr == (o_buffer_mode != BUF_SIMPLIFIED);
	endproperty
	a_follow: assert property (p_follow)
		else $error("data pointers used in simplified mode");
	property p_irq_rise;
		$rose(o_irq) |-> $past(i_msg_done)
			|| $past(i_psel && i_penable && i_pwrite);
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("interrupt rose without a cause");
	// Log only follows an accepted message one cycle earlier
	property p_log;
		o_log_valid |-> $past(i_msg_done && i_msg_valid && o_rx_word_select);
	endproperty
	a_log: assert property (p_log)
		else $error("log pulse without message");
	property p_log_code;
		o_log_valid |-> o_log_code != 2'h0;
	endproperty
	a_log_code: assert property (p_log_code)
		else $error("log pulse with empty cause");
	property p_ptr;
		$rose(o_use_pointer_b) |-> $past(i_msg_done && i_msg_error_free
			&& !o_make_busy && o_buffer_mode == BUF_DOUBLE);
	endproperty
	a_ptr: assert property (p_ptr)
		else $error("pointer select rose without good message");
	c_irq: cover property ($rose(o_irq));
	c_log_idx: cover property (o_log_valid && o_log_code[0]);
	c_log_acc: cover property (o_log_valid && o_log_code[1]);
endmodule

bind rmcc_top rmcc_props u_props (.i_sys_clk(i_sys_clk),
	.i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_msg_done(i_msg_done),
	.i_msg_valid(i_msg_valid), .i_msg_tr(i_msg_tr),
	.i_msg_subaddr(i_msg_subaddr), .i_msg_mode_code(i_msg_mode_code),
	.i_msg_error_free(i_msg_error_free), .o_buffer_mode(o_buffer_mode),
	.o_rx_word_select(o_rx_word_select),
	.o_use_pointer_b(o_use_pointer_b),
	.o_follow_data_ptr(o_follow_data_ptr),
	.o_store_in_desc(o_store_in_desc), .o_make_busy(o_make_busy),
	.o_log_valid(o_log_valid), .o_log_code(o_log_code), .o_irq(o_irq));

// >>> tb/rmcc_msg_model.sv
// Model of the protocol engine reporting finished mode commands
module rmcc_msg_model
(
	input  wire logic  i_sys_clk,    // System clock
	output logic       o_done,       // Finished pulse
	output logic       o_valid,      // Valid command
	output logic       o_tr,         // T/R bit
	output logic [4:0] o_subaddr,    // Subaddress
	output logic [4:0] o_mode_code,  // Mode code
	output logic       o_error_free, // No error seen
	output logic       o_broadcast   // Broadcast command
);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet at time zero
	initial
	begin
		{o_done, o_valid, o_tr, o_subaddr} = 8'h00;
		{o_mode_code, o_error_free, o_broadcast} = 7'h00;
	end

	// One pulse; valid, T/R, subaddress and error-free flip afterwards so none is trusted late
	task automatic send(input logic t, input logic [4:0] s,
		input logic [4:0] m, input logic e, input logic b);
		@(posedge i_sys_clk);
		o_done       <= 1'b1;
		o_valid      <= 1'b1;
		o_tr         <= t;
		o_subaddr    <= s;
		o_mode_code  <= m;
		o_error_free <= e;
		o_broadcast  <= b;
		@(posedge i_sys_clk);
		o_done       <= 1'b0;
		o_valid      <= ~o_valid;
		o_tr         <= ~o_tr;
		o_subaddr    <= ~o_subaddr;
		o_error_free <= ~o_error_free;
		@(negedge i_sys_clk);
	endtask
endmodule

// >>> tb/rmcc_top_test.sv
// Self-checking bench for the mode command control word block
module rmcc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import rmcc_pkg::*;

	logic        i_sys_clk = 1'b0, i_resetn = 1'b0, mr_pin = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, slv_err, done, valid, tr, ef, bc;
	logic [4:0]  sub, mc;
	logic        rx_sel, ptr_b, follow, store, busy, log_v, irq;
	logic [1:0]  log_c;
	rmcc_buf_mode_type bmode;
	int          err_count = 0, n_checks = 0;

	always #10 i_sys_clk = ~i_sys_clk;

	rmcc_msg_model u_msg (.i_sys_clk(i_sys_clk), .o_done(done),
		.o_valid(valid), .o_tr(tr), .o_subaddr(sub), .o_mode_code(mc),
		.o_error_free(ef), .o_broadcast(bc));

	rmcc_top dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_master_reset_pin(mr_pin), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_msg_done(done), .i_msg_valid(valid), .i_msg_tr(tr),
		.i_msg_subaddr(sub), .i_msg_mode_code(mc),
		.i_msg_error_free(ef), .i_msg_broadcast(bc),
		.o_buffer_mode(bmode), .o_rx_word_select(rx_sel),
		.o_use_pointer_b(ptr_b), .o_follow_data_ptr(follow),
		.o_store_in_desc(store), .o_make_busy(busy),
		.o_log_valid(log_v), .o_log_code(log_c), .o_irq(irq));

	// ************************************************
	// Shared tasks
	// ************************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// APB transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge i_sys_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		n = 0;
		do
			@(posedge i_sys_clk);
		while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
		begin
			err_count++;
			$display("mismatch at %0t: no ready", $time);
			stop_test();
		end
		rdat    = prdata;
		slv_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge i_sys_clk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_reset();
		rc(8'h00, 32'h0);
		rc(8'h18, 32'h0);
		chk(slv_err, 1'b1);
		chk(32'(bmode), 32'(BUF_INDEXED));
		chk(irq, 1'b0);
		$display("reset test done");
	endtask

	task automatic t_rights();
		apb(1'b1, 8'h00, 32'h0000FFFF);
		rc(8'h00, 32'h0000F0FC);
		chk(busy, 1'b1);
		apb(1'b1, 8'h04, 32'h6);
		apb(1'b1, 8'h00, 32'h0);
		rc(8'h00, 32'h000001F4);
		chk(32'(bmode), 32'(BUF_DOUBLE));
		chk(follow, 1'b1);
		apb(1'b1, 8'h04, 32'h7);
		chk(32'(bmode), 32'(BUF_SIMPLIFIED));
		chk(follow, 1'b0);
		rc(8'h00, 32'h000000F4);
		rc(8'h14, 32'h2);
		$display("write rights test done");
	endtask

	task automatic t_index();
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h00008020);
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h04, 32'hE);
		u_msg.send(1'b0, 5'h00, 5'h01, 1'b1, 1'b0);
		rc(8'h00, 32'h00008810);
		chk(irq, 1'b0);
		u_msg.send(1'b0, 5'h00, 5'h01, 1'b1, 1'b1);
		chk(irq, 1'b1);
		rc(8'h0C, 32'h1);
		rc(8'h00, 32'h00008A00);
		rc(8'h00, 32'h00008200);
		apb(1'b1, 8'h10, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, 8'h10, 32'h1);
		chk(irq, 1'b1);
		apb(1'b1, 8'h0C, 32'h1);
		chk(irq, 1'b0);
		u_msg.send(1'b0, 5'h00, 5'h01, 1'b1, 1'b0);
		rc(8'h0C, 32'h0);
		rc(8'h00, 32'h00008800);
		$display("index test done");
	endtask

	task automatic t_access();
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h04, 32'h16);
		apb(1'b1, 8'h00, 32'h00004000);
		u_msg.send(1'b1, 5'h00, 5'h02, 1'b1, 1'b1);
		u_msg.send(1'b0, 5'h05, 5'h02, 1'b1, 1'b1);
		rc(8'h0C, 32'h0);
		rc(8'h00, 32'h00004000);
		u_msg.send(1'b0, 5'h1F, 5'h10, 1'b1, 1'b1);
		chk(irq, 1'b1);
		rc(8'h0C, 32'h2);
		rc(8'h00, 32'h00004A00);
		apb(1'b1, 8'h0C, 32'h2);
		$display("access test done");
	endtask

	task automatic t_double();
		logic [3:0] ef_pat = 4'b1101;
		logic [3:0] ptr_pat = 4'b1011;
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, 8'h00, 32'h4);
		apb(1'b1, 8'h04, 32'h6);
		// Error-free pattern 1,0,1,1 gives pointer 1,1,0,1
		for (int k = 0; k < 4; k++)
		begin
			u_msg.send(1'b0, 5'h00, 5'h02, ef_pat[k], 1'b1);
			chk(ptr_b, ptr_pat[k]);
		end
		rc(8'h00, 32'h00000F04);
		apb(1'b1, 8'h08, 32'h1);
		rc(8'h00, 32'h00000104);
		// Read clear lands on the same edge as a completion
		fork
			rc(8'h00, 32'h00000104);
			begin
				@(posedge i_sys_clk);
				u_msg.send(1'b0, 5'h00, 5'h02, 1'b0, 1'b0);
			end
		join
		rc(8'h00, 32'h00000904);
		$display("double buffer test done");
	endtask

	task automatic t_master();
		mr_pin <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		mr_pin <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		rc(8'h00, 32'h0);
		rc(8'h04, 32'h0);
		$display("master reset test done");
	endtask

	initial
	begin
		repeat (10) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_rights();
		t_index();
		t_access();
		t_double();
		t_master();
		stop_test();
	end
endmodule
